//--- rtl/vip_alu_dev.sv
`timescale 1ns/10ps
`include "vip_consts.svh"
// How it works
// - op 216 decodes as first-component interpolation
// - first-component op pairs lanes y and x
// - pair-low op uses all lanes, z to y
// - op 214 decodes as pair-low interpolation
// - third-component op pairs lanes w and z
// - op 217 decodes as third-component interpolation
// - pair-high op: z to y, x to w
// - op 215 decodes as pair-high interpolation
// - result is first plus second*i plus third*j
// - multiply-add feeds dot add without rounding
// - op 44 discards on float equal
// - op 70 discards on integer equal
// - op 46 discards on float greater-or-equal
// - op 72 discards on integer greater-or-equal
// - op 65 discards on unsigned greater-or-equal
// - op 45 discards on float greater
// - op 71 discards on signed greater
// - unsigned greater compares without sign
// - op 64 decodes as unsigned greater discard
// - true writes one and kills, false zero
// - discards act only in pixel programs
// - kill state shows one cycle later
// - sequencer refuses a discard that is not last in its clause
module vip_alu_dev (
	input  wire logic                 clk_sys_i,
	input  wire logic                 arst_n_i,
	vip_alu_if.dev                    alu_if,
	input  wire logic                 gpr_ready_i,
	input  wire logic                 pix_start_i,
	output logic                      gpr_wr_valid_o,
	output logic [3:0]                gpr_wr_en_o,
	output vip_pkg::vip_vec_t         gpr_wr_data_o,
	output logic                      pix_valid_o
);
	logic              wr_valid_reg;
	logic [3:0]        wr_en_reg;
	vip_pkg::vip_vec_t wr_data_reg;
	logic              killed_reg;
	logic              done_reg;
	logic              err_reg;
	logic [3:0]        we_next;
	vip_pkg::vip_vec_t data_next;
	logic              kill_next;
	logic              err_next;
	logic              take;
	logic [31:0]       res_x;
	logic [31:0]       res_z;

	function automatic logic [23:0] f_mant(input logic [31:0] a);
		return (a[30:23] == 8'h00) ? 24'h000000 : {1'b1, a[22:0]};
	endfunction

	function automatic vip_pkg::vip_ext_t f_unp(input logic [31:0] a);
		vip_pkg::vip_ext_t r;
		r.s = a[31];
		r.e = {2'h0, a[30:23]};
		r.m = {1'b0, f_mant(a), 23'h000000};
		return r;
	endfunction

	function automatic vip_pkg::vip_ext_t f_mul(input logic [31:0] a, input logic [31:0] b);
		vip_pkg::vip_ext_t r;
		r.s = a[31] ^ b[31];
		r.e = $signed({2'h0, a[30:23]}) + $signed({2'h0, b[30:23]}) - $signed(`VIP_F_BIAS);
		r.m = f_mant(a) * f_mant(b);
		return r;
	endfunction

	// aligned add in a wide sum, so a cancelling dot add keeps the low mul-add bits;
	// only bits beyond the 48 most significant ones are cut
	function automatic vip_pkg::vip_ext_t f_add(input vip_pkg::vip_ext_t x_in,
		input vip_pkg::vip_ext_t y_in);
		vip_pkg::vip_ext_t x;
		vip_pkg::vip_ext_t y;
		vip_pkg::vip_ext_t r;
		logic [9:0]        d;
		logic [96:0]       a;
		logic [96:0]       b;
		logic [96:0]       s;
		logic [6:0]        q;
		x = (x_in.e >= y_in.e) ? x_in : y_in;
		y = (x_in.e >= y_in.e) ? y_in : x_in;
		d = 10'(x.e - y.e);
		a = {1'b0, x.m, 48'h000000000000};
		b = (d > 10'h030) ? 97'h0 : ({1'b0, y.m, 48'h000000000000} >> d);
		r.s = x.s;
		if (x.s == y.s) begin
			s = a + b;
		end else if (a >= b) begin
			s = a - b;
		end else begin
			s = b - a;
			r.s = y.s;
		end
		q = 7'h00;
		for (int k = 0; k < 97; k++) begin
			if (s[k]) begin
				q = 7'(k);
			end
		end
		if (q > 7'h2F) begin
			r.m = 48'(s >> (q - 7'h2F));
			r.e = x.e - 10'sh030 + $signed({3'h0, q - 7'h2F});
		end else begin
			r.m = s[47:0];
			r.e = x.e - 10'sh030;
		end
		return r;
	endfunction

	// single truncation to single precision; tiny results flush to zero
	function automatic logic [31:0] f_pack(input vip_pkg::vip_ext_t r);
		logic [5:0]         p;
		logic signed [10:0] be;
		logic [47:0]        n;
		p = 6'h00;
		for (int k = 0; k < 48; k++) begin
			if (r.m[k]) begin
				p = 6'(k);
			end
		end
		be = 11'(r.e) + $signed({5'h00, p}) - 11'sh02E;
		n = r.m << (6'h2F - p);
		if (r.m == 48'h0 || be <= 11'sh000) begin
			return {r.s, 31'h00000000};
		end else if (be >= 11'sh0FF) begin
			return {r.s, `VIP_F_EXP_MAX, 23'h000000};
		end
		return {r.s, be[7:0], n[46:24]};
	endfunction

	// float order: {greater, equal}; nan compares false, zeros are equal
	function automatic logic [1:0] f_cmp(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] ka;
		logic [31:0] kb;
		logic        eq;
		if ((a[30:23] == `VIP_F_EXP_MAX && a[22:0] != 23'h0) ||
			(b[30:23] == `VIP_F_EXP_MAX && b[22:0] != 23'h0)) begin
			return 2'h0;
		end
		ka = a[31] ? ~a : (a | 32'h80000000);
		kb = b[31] ? ~b : (b | 32'h80000000);
		eq = (a == b) || (a[30:0] == 31'h0 && b[30:0] == 31'h0);
		return {!eq && ka > kb, eq};
	endfunction

	function automatic logic kill_hit(input vip_pkg::vip_op_t op, input logic [31:0] a,
		input logic [31:0] b);
		logic [1:0] c;
		c = f_cmp(a, b);
		case (op)
			`VIP_OP_FLT_EQ: return c[0];
			`VIP_OP_FLT_GE: return c[1] | c[0];
			`VIP_OP_FLT_GT: return c[1];
			`VIP_OP_INT_EQ: return a == b;
			`VIP_OP_INT_GE: return $signed(a) >= $signed(b);
			`VIP_OP_UNS_GE: return a >= b;
			`VIP_OP_INT_GT: return $signed(a) > $signed(b);
			`VIP_OP_UNS_GT: return a > b;
			default: return 1'b0;
		endcase
	endfunction

	// mul-add lanes y and w form first + second*i, dot lanes x and z add third*j
	always_comb begin
		res_x = f_pack(f_add(f_add(f_unp(alu_if.src2[1]), f_mul(alu_if.src0[1], alu_if.src1[1])),
			f_mul(alu_if.src0[0], alu_if.src1[0])));
		res_z = f_pack(f_add(f_add(f_unp(alu_if.src2[3]), f_mul(alu_if.src0[3], alu_if.src1[3])),
			f_mul(alu_if.src0[2], alu_if.src1[2])));
	end

	// steer interpolation results and evaluate discards per lane
	always_comb begin
		logic [3:0] cov;
		cov = vip_pkg::vip_interp_cov(alu_if.lane_op);
		we_next = 4'h0;
		data_next = '0;
		kill_next = 1'b0;
		err_next = 1'b0;
		if (cov == 4'hF && alu_if.lane_op[0] == `VIP_OP_BARY_PAIR_LO) begin
			data_next[0] = res_x;
			data_next[1] = res_z;
			we_next = `VIP_WE_PAIR_LO;
		end else if (cov == 4'hF) begin
			data_next[1] = res_z;
			data_next[3] = res_x;
			we_next = `VIP_WE_PAIR_HI;
		end else begin
			if (cov[0]) begin
				data_next[0] = res_x;
				we_next = we_next | `VIP_WE_FIRST;
			end
			if (cov[2]) begin
				data_next[2] = res_z;
				we_next = we_next | `VIP_WE_THIRD;
			end
		end
		for (int l = 0; l < 4; l++) begin
			if (vip_pkg::vip_is_interp(alu_if.lane_op[l]) && !cov[l]) begin
				err_next = 1'b1; // a half-issued pairing writes nothing
			end
			if (vip_pkg::vip_is_kill(alu_if.lane_op[l]) && alu_if.pixel_prog) begin
				we_next[l] = 1'b1;
				if (kill_hit(alu_if.lane_op[l], alu_if.src0[l], alu_if.src1[l])) begin
					data_next[l] = `VIP_F_ONE;
					kill_next = 1'b1;
				end else begin
					data_next[l] = `VIP_F_ZERO;
				end
			end
		end
	end

	// a group is taken when no write is pending or the pending write drains on the same edge
	assign alu_if.grp_ready = !wr_valid_reg || gpr_ready_i;
	assign take = alu_if.grp_valid && alu_if.grp_ready;

	// register file write stage
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_valid_reg <= 1'b0;
			wr_en_reg <= 4'h0;
			wr_data_reg <= '0;
		end else if (take) begin
			wr_valid_reg <= 1'b1;
			wr_en_reg <= we_next;
			wr_data_reg <= data_next;
		end else if (gpr_ready_i) begin
			wr_valid_reg <= 1'b0;
		end
	end

	// completion pulse back to the sequencer
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			done_reg <= take;
			err_reg <= take && err_next;
		end
	end

	// kill bit: set beats a same-cycle new-pixel clear
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			killed_reg <= 1'b0;
		end else if (take && kill_next) begin
			killed_reg <= 1'b1;
		end else if (pix_start_i) begin
			killed_reg <= 1'b0;
		end
	end

	assign alu_if.grp_done = done_reg;
	assign alu_if.grp_err = err_reg;
	assign gpr_wr_valid_o = wr_valid_reg;
	assign gpr_wr_en_o = wr_en_reg;
	assign gpr_wr_data_o = wr_data_reg;
	assign pix_valid_o = !killed_reg; // lags the discard by one edge
endmodule

//--- rtl/vip_alu_if.sv
`timescale 1ns/10ps
// issue path from sequencer to the alu slice; lane 0..3 = x, y, z, w
interface vip_alu_if;
	logic              grp_valid;
	logic              grp_ready;
	vip_pkg::vip_ops_t lane_op;
	vip_pkg::vip_vec_t src0;
	vip_pkg::vip_vec_t src1;
	vip_pkg::vip_vec_t src2;
	logic              pixel_prog;
	logic              grp_done;
	logic              grp_err;

	modport dev (
		input  grp_valid, lane_op, src0, src1, src2, pixel_prog,
		output grp_ready, grp_done, grp_err
	);
	modport hst (
		output grp_valid, lane_op, src0, src1, src2, pixel_prog,
		input  grp_ready, grp_done, grp_err
	);
endinterface

//--- rtl/vip_consts.svh
`ifndef VIP_CONSTS_SVH
`define VIP_CONSTS_SVH
// instruction field and datapath widths
`define VIP_OP_W 11
`define VIP_DW 32
// two- and three-source opcodes handled by this slice
`define VIP_OP_BARY_FIRST 11'h0D8
`define VIP_OP_BARY_PAIR_LO 11'h0D6
`define VIP_OP_BARY_THIRD 11'h0D9
`define VIP_OP_BARY_PAIR_HI 11'h0D7
`define VIP_OP_FLT_EQ 11'h02C
`define VIP_OP_FLT_GT 11'h02D
`define VIP_OP_FLT_GE 11'h02E
`define VIP_OP_INT_EQ 11'h046
`define VIP_OP_INT_GT 11'h047
`define VIP_OP_INT_GE 11'h048
`define VIP_OP_UNS_GT 11'h040
`define VIP_OP_UNS_GE 11'h041
// single precision constants
`define VIP_F_ONE 32'h3F800000
`define VIP_F_ZERO 32'h00000000
`define VIP_F_BIAS 10'h07F
`define VIP_F_EXP_MAX 8'hFF
// lane write masks for the interpolation steering
`define VIP_WE_FIRST 4'h1
`define VIP_WE_THIRD 4'h4
`define VIP_WE_PAIR_LO 4'h3
`define VIP_WE_PAIR_HI 4'hA
`endif

//--- rtl/vip_pkg.sv
`include "vip_consts.svh"
package vip_pkg;
	typedef logic [`VIP_OP_W-1:0] vip_op_t;
	typedef logic [3:0][`VIP_OP_W-1:0] vip_ops_t;
	typedef logic [3:0][`VIP_DW-1:0] vip_vec_t;
	// unrounded value: m * 2^(e - bias - 46)
	typedef struct packed {
		logic               s;
		logic signed [9:0]  e;
		logic [47:0]        m;
	} vip_ext_t;
	typedef enum logic [1:0] {
		VIP_S_IDLE = 2'b00,
		VIP_S_SEND = 2'b01,
		VIP_S_WAIT = 2'b10
	} vip_hst_t;

	function automatic logic vip_is_kill(input vip_op_t op);
		case (op)
			`VIP_OP_FLT_EQ, `VIP_OP_FLT_GT, `VIP_OP_FLT_GE, `VIP_OP_INT_EQ,
			`VIP_OP_INT_GT, `VIP_OP_INT_GE, `VIP_OP_UNS_GT, `VIP_OP_UNS_GE: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic vip_is_interp(input vip_op_t op);
		return op == `VIP_OP_BARY_FIRST || op == `VIP_OP_BARY_PAIR_LO ||
			op == `VIP_OP_BARY_THIRD || op == `VIP_OP_BARY_PAIR_HI;
	endfunction

	// lanes that sit in a legal interpolation pairing
	function automatic logic [3:0] vip_interp_cov(input vip_ops_t op);
		logic [3:0] c;
		c = 4'h0;
		if (op[0] == `VIP_OP_BARY_PAIR_LO && op[1] == `VIP_OP_BARY_PAIR_LO &&
			op[2] == `VIP_OP_BARY_PAIR_LO && op[3] == `VIP_OP_BARY_PAIR_LO) begin
			c = 4'hF;
		end else if (op[0] == `VIP_OP_BARY_PAIR_HI && op[1] == `VIP_OP_BARY_PAIR_HI &&
			op[2] == `VIP_OP_BARY_PAIR_HI && op[3] == `VIP_OP_BARY_PAIR_HI) begin
			c = 4'hF;
		end else begin
			if (op[0] == `VIP_OP_BARY_FIRST && op[1] == `VIP_OP_BARY_FIRST) begin
				c[1:0] = 2'h3;
			end
			if (op[2] == `VIP_OP_BARY_THIRD && op[3] == `VIP_OP_BARY_THIRD) begin
				c[3:2] = 2'h3;
			end
		end
		return c;
	endfunction
endpackage

//--- rtl/vip_seq_host.sv
`timescale 1ns/10ps
`include "vip_consts.svh"
module vip_seq_host (
	input  wire logic                 clk_sys_i,
	input  wire logic                 arst_n_i,
	vip_alu_if.hst                    alu_if,
	input  wire logic                 req_valid_i,
	output logic                      req_ready_o,
	input  wire vip_pkg::vip_ops_t    req_op_i,
	input  wire vip_pkg::vip_vec_t    req_src0_i,
	input  wire vip_pkg::vip_vec_t    req_src1_i,
	input  wire vip_pkg::vip_vec_t    req_src2_i,
	input  wire logic                 req_pixel_i,
	input  wire logic                 req_last_i,
	output logic                      rej_o,
	output logic                      done_o,
	output logic                      err_o
);
	vip_pkg::vip_hst_t state_reg;
	vip_pkg::vip_ops_t op_reg;
	vip_pkg::vip_vec_t src0_reg;
	vip_pkg::vip_vec_t src1_reg;
	vip_pkg::vip_vec_t src2_reg;
	logic              pix_reg;
	logic              rej_reg;
	logic              done_reg;
	logic              err_reg;
	logic              legal;
	logic              accept;

	// refuse broken pairings and a discard that is not last in its clause
	always_comb begin
		logic [3:0] cov;
		cov = vip_pkg::vip_interp_cov(req_op_i);
		legal = 1'b1;
		for (int l = 0; l < 4; l++) begin
			if (vip_pkg::vip_is_interp(req_op_i[l]) && !cov[l]) begin
				legal = 1'b0;
			end
			if (vip_pkg::vip_is_kill(req_op_i[l]) && !req_last_i) begin
				legal = 1'b0;
			end
		end
	end

	assign req_ready_o = state_reg == vip_pkg::VIP_S_IDLE;
	assign accept = req_valid_i && req_ready_o;

	// one group in flight; the slice answers one edge after it takes it
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= vip_pkg::VIP_S_IDLE;
		end else begin
			case (state_reg)
				vip_pkg::VIP_S_IDLE: begin
					if (accept && legal) begin
						state_reg <= vip_pkg::VIP_S_SEND;
					end
				end
				vip_pkg::VIP_S_SEND: begin
					if (alu_if.grp_ready) begin
						state_reg <= vip_pkg::VIP_S_WAIT;
					end
				end
				vip_pkg::VIP_S_WAIT: begin
					if (alu_if.grp_done) begin
						state_reg <= vip_pkg::VIP_S_IDLE;
					end
				end
				default: state_reg <= vip_pkg::VIP_S_IDLE;
			endcase
		end
	end

	// group held stable while offered
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			op_reg <= '0;
			src0_reg <= '0;
			src1_reg <= '0;
			src2_reg <= '0;
			pix_reg <= 1'b0;
		end else if (accept && legal) begin
			op_reg <= req_op_i;
			src0_reg <= req_src0_i;
			src1_reg <= req_src1_i;
			src2_reg <= req_src2_i;
			pix_reg <= req_pixel_i;
		end
	end

	// status pulses to the user side
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rej_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			rej_reg <= accept && !legal;
			done_reg <= alu_if.grp_done;
			err_reg <= alu_if.grp_done && alu_if.grp_err;
		end
	end

	assign alu_if.grp_valid = state_reg == vip_pkg::VIP_S_SEND;
	assign alu_if.lane_op = op_reg;
	assign alu_if.src0 = src0_reg;
	assign alu_if.src1 = src1_reg;
	assign alu_if.src2 = src2_reg;
	assign alu_if.pixel_prog = pix_reg;
	assign rej_o = rej_reg;
	assign done_o = done_reg;
	assign err_o = err_reg;
endmodule

//--- testbench/vector_interp_and_pixel_discard_test.sv
`timescale 1ns/10ps
`include "vip_consts.svh"
module vector_interp_and_pixel_discard_test;
	logic              clk_sys_i = 1'b0;
	logic              arst_n_i = 1'b0;
	logic              vld = 1'b0, pix = 1'b1, last = 1'b1, rdy = 1'b1, pst = 1'b0;
	logic              ready, rej, done, err, wv, pv;
	logic [3:0]        en, en_seen;
	vip_pkg::vip_ops_t op = '0;
	vip_pkg::vip_vec_t s0 = '0, s1 = '0, s2 = '0, wd, wd_seen;
	int                n_mismatch = 0, checks_done = 0, cyc = 0;

	vip_alu_if alu_if ();
	vip_seq_host vip_seq_host_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.alu_if(alu_if.hst), .req_valid_i(vld), .req_ready_o(ready), .req_op_i(op),
		.req_src0_i(s0), .req_src1_i(s1), .req_src2_i(s2), .req_pixel_i(pix),
		.req_last_i(last), .rej_o(rej), .done_o(done), .err_o(err));
	vip_alu_dev vip_alu_dev_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.alu_if(alu_if.dev), .gpr_ready_i(rdy), .pix_start_i(pst), .gpr_wr_valid_o(wv),
		.gpr_wr_en_o(en), .gpr_wr_data_o(wd), .pix_valid_o(pv));
	vip_alu_asserts vip_alu_asserts_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.grp_valid(alu_if.grp_valid), .grp_ready(alu_if.grp_ready),
		.lane_op(alu_if.lane_op), .pixel_prog(alu_if.pixel_prog),
		.grp_done(alu_if.grp_done), .grp_err(alu_if.grp_err));

	always #5 clk_sys_i = ~clk_sys_i;

	// keep the write that the register file really accepted
	always @(posedge clk_sys_i) begin
		if (vld && ready) begin
			en_seen <= 4'h0; // forget the last write enables once the sequencer accepts a new request
		end else if (wv && rdy) begin
			en_seen <= en;
			wd_seen <= wd;
		end
	end

	// a hang would otherwise stall the run forever
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// offer one group, hold it to the accepting edge, wait for the answer
	task automatic send(input vip_pkg::vip_ops_t o, input logic p, input logic l);
		int k;
		k = 0;
		while (!ready) @(posedge clk_sys_i) #1;
		op = o;
		pix = p;
		last = l;
		vld = 1'b1;
		@(posedge clk_sys_i) #1;
		vld = 1'b0;
		while (!(done || rej) && k < 40) begin
			@(posedge clk_sys_i) #1;
			k++;
		end
		check({31'h0, done || rej}, 32'h00000001);
	endtask

	task automatic t_interp();
		s0 = {32'h40000000, 32'h40800000, 32'h40000000, 32'h40800000};
		s1 = {32'h3F000000, 32'h3E800000, 32'h3F000000, 32'h3E800000};
		s2 = {32'h40000000, 32'h00000000, `VIP_F_ONE, 32'h00000000};
		send({22'h0, `VIP_OP_BARY_FIRST, `VIP_OP_BARY_FIRST}, 1'b1, 1'b1);
		check({28'h0, en_seen}, 32'h00000001);
		check(wd_seen[0], 32'h40400000);
		check({31'h0, err}, 32'h00000000);
		send({`VIP_OP_BARY_THIRD, `VIP_OP_BARY_THIRD, 22'h0}, 1'b1, 1'b1);
		check({28'h0, en_seen}, 32'h00000004);
		check(wd_seen[2], 32'h40800000);
		send({4{`VIP_OP_BARY_PAIR_LO}}, 1'b1, 1'b1);
		check({28'h0, en_seen}, 32'h00000003);
		check(wd_seen[0], 32'h40400000);
		check(wd_seen[1], 32'h40800000);
		send({4{`VIP_OP_BARY_PAIR_HI}}, 1'b1, 1'b1);
		check({28'h0, en_seen}, 32'h0000000A);
		check(wd_seen[1], 32'h40800000);
		check(wd_seen[3], 32'h40400000);
		// register file stalls: the write must wait, not be lost
		rdy = 1'b0;
		fork
			send({22'h0, `VIP_OP_BARY_FIRST, `VIP_OP_BARY_FIRST}, 1'b1, 1'b1);
			begin
				repeat (5) @(posedge clk_sys_i) #1;
				check({31'h0, wv}, 32'h00000001);
				rdy = 1'b1;
			end
		join
		@(posedge clk_sys_i) #1;
		check(wd_seen[0], 32'h40400000);
		// a lone first component op has no partner lane
		send({33'h0, `VIP_OP_BARY_FIRST}, 1'b1, 1'b1);
		check({31'h0, rej}, 32'h00000001);
		// exact sum is 2^-46; rounding the product sum first would give zero
		s0 = {64'h0, 32'h3F800001, 32'hC0000001};
		s1 = {64'h0, 32'h3F800001, `VIP_F_ONE};
		s2 = {64'h0, `VIP_F_ONE, 32'h00000000};
		send({22'h0, `VIP_OP_BARY_FIRST, `VIP_OP_BARY_FIRST}, 1'b1, 1'b1);
		check(wd_seen[0], 32'h28800000);
		$display("t_interp finished");
	endtask

	// lane x holds a true compare, lane y a false one
	task automatic t_kill();
		logic [10:0] ko [8] = '{`VIP_OP_FLT_EQ, `VIP_OP_FLT_GT, `VIP_OP_FLT_GE,
			`VIP_OP_INT_EQ, `VIP_OP_INT_GT, `VIP_OP_INT_GE, `VIP_OP_UNS_GT, `VIP_OP_UNS_GE};
		logic [31:0] kv [8][4] = '{
			'{32'h80000000, 32'h00000000, 32'h3F800000, 32'h40000000},
			'{32'hBF800000, 32'hC0000000, 32'h3F800000, 32'h3F800000},
			'{32'hBF800000, 32'hC0000000, 32'hC0000000, 32'hBF800000},
			'{32'h00000005, 32'h00000005, 32'h80000000, 32'h00000000},
			'{32'h00000001, 32'hFFFFFFFF, 32'h00000005, 32'h00000005},
			'{32'h00000001, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000001},
			'{32'hFFFFFFFF, 32'h00000001, 32'h00000005, 32'h00000005},
			'{32'hFFFFFFFF, 32'h00000001, 32'h00000001, 32'hFFFFFFFF}};
		s2 = '0;
		for (int i = 0; i < 8; i++) begin
			s0 = {64'h0, kv[i][2], kv[i][0]};
			s1 = {64'h0, kv[i][3], kv[i][1]};
			send({22'h0, ko[i], ko[i]}, 1'b1, 1'b1);
			check({28'h0, en_seen}, 32'h00000003);
			check(wd_seen[0], `VIP_F_ONE);
			check(wd_seen[1], `VIP_F_ZERO);
			check({31'h0, pv}, 32'h00000000);
			pst = 1'b1;
			@(posedge clk_sys_i) #1;
			pst = 1'b0;
			check({31'h0, pv}, 32'h00000001);
		end
		// outside a pixel program the same true compare does nothing
		send({22'h0, ko[7], ko[7]}, 1'b0, 1'b1);
		check({28'h0, en_seen}, 32'h00000000);
		check({31'h0, pv}, 32'h00000001);
		// a discard that is not last in its clause is turned away
		send({22'h0, ko[7], ko[7]}, 1'b1, 1'b0);
		check({31'h0, rej}, 32'h00000001);
		check({31'h0, pv}, 32'h00000001);
		$display("t_kill finished");
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// reset for three cycles, then the scenarios in turn
	initial begin
		repeat (3) @(posedge clk_sys_i) #1;
		arst_n_i = 1'b1;
		t_interp();
		t_kill();
		end_of_test();
	end
endmodule

//--- testbench/vip_alu_asserts.sv
`timescale 1ns/10ps
`include "vip_consts.svh"
// watches the issue path between the sequencer and the slice
module vip_alu_asserts (
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	input  wire logic              grp_valid,
	input  wire logic              grp_ready,
	input  wire vip_pkg::vip_ops_t lane_op,
	input  wire logic              pixel_prog,
	input  wire logic              grp_done,
	input  wire logic              grp_err
);
	logic take;

	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	// a group is taken when offered and accepted on the same edge
	assign take = grp_valid && grp_ready;

	done_after_take_a: assert property (take |=> grp_done)
		else $error("group taken but no done pulse");
	done_needs_take_a: assert property (grp_done |-> $past(take))
		else $error("done pulse without a taken group");
	one_in_flight_a: assert property (take |=> !grp_valid ##1 !grp_valid)
		else $error("second group offered while one in flight");
	first_pair_ok_a: assert property (take && lane_op == {22'h0,
		`VIP_OP_BARY_FIRST, `VIP_OP_BARY_FIRST} |=> !grp_err)
		else $error("legal first component pair flagged");
	third_pair_ok_a: assert property (take && lane_op == {`VIP_OP_BARY_THIRD,
		`VIP_OP_BARY_THIRD, 22'h0} |=> grp_done && !grp_err)
		else $error("legal third component pair flagged");
	pair_low_ok_a: assert property (take && lane_op == {4{`VIP_OP_BARY_PAIR_LO}}
		|=> grp_done && !grp_err)
		else $error("legal pair low group flagged");
	pair_high_ok_a: assert property (take && lane_op == {4{`VIP_OP_BARY_PAIR_HI}}
		|=> grp_done && !grp_err)
		else $error("legal pair high group flagged");
	discard_ok_a: assert property (take && lane_op[0] == `VIP_OP_FLT_EQ
		|=> $fell(grp_valid) && !grp_err)
		else $error("discard group flagged as error");

	cover_pixel_c: cover property (take && pixel_prog);
	cover_other_c: cover property (take && !pixel_prog);
	cover_pair_c: cover property (take && lane_op == {4{`VIP_OP_BARY_PAIR_HI}});
endmodule
